/* rss_regs.svh */
// Register offsets, field positions, reset values and timing counts of the rail strobe sequencer.
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH

`define RSS_ADDR_DELAY_LOW      8'h20
`define RSS_ADDR_DELAY_HIGH     8'h21
`define RSS_ADDR_BUCK_ASSIGN    8'h22

`define RSS_RST_DELAY_LOW       8'h00
`define RSS_RST_DELAY_HIGH      8'h00
`define RSS_RST_BUCK_ASSIGN     8'h98

`define RSS_BIT_PD_MULT         7
`define RSS_BIT_GAP_NINE        0
`define RSS_HIGH_RW_MASK        8'h81
`define RSS_BUCK_TWO_MSB        7
`define RSS_BUCK_TWO_LSB        4
`define RSS_BUCK_ONE_MSB        3
`define RSS_BUCK_ONE_LSB        0

`define RSS_SLOT_FIRST          4'h3
`define RSS_SLOT_LAST           4'ha
`define RSS_STROBE_FIRST        4'h1
`define RSS_STROBE_LAST         4'ha

`define RSS_SYS_CLK_KHZ         10000
`define RSS_GAP_SHORT_US        2000
`define RSS_GAP_LONG_US         5000
`define RSS_PD_FACTOR           10
`define RSS_GAP_SHORT_CYC       ((`RSS_GAP_SHORT_US * `RSS_SYS_CLK_KHZ) / 1000)
`define RSS_GAP_LONG_CYC        ((`RSS_GAP_LONG_US * `RSS_SYS_CLK_KHZ) / 1000)

`endif

/* rss_pkg.sv */
// Types shared by the rail strobe sequencer modules.
`default_nettype none
package rss_pkg;
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rss_reg_req_t;

   typedef enum logic [1:0] {RSS_IDLE, RSS_UP, RSS_DOWN} rss_state_t;
endpackage : rss_pkg
`default_nettype wire

/* rss_gap_timer.sv */
// Down counter that times one inter-strobe gap.
`default_nettype none
module rss_gap_timer
   import rss_pkg::*;
#(
   parameter int CW = 20
) (
   input  wire logic          i_sys_clk,
   input  wire logic          i_rst_b,
   input  wire logic          i_start,
   input  wire logic [CW-1:0] i_load,
   output logic               o_done
);
   logic [CW-1:0] cnt_q;

   // Count down from the load value; a new start restarts the gap.
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         cnt_q <= '0;
      end else if (i_start) begin
         cnt_q <= i_load;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - CW'(1);
      end
   end

   // Done pulses one cycle after the last count, so it is a clean flop output.
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         o_done <= 1'b0;
      end else begin
         o_done <= !i_start && (cnt_q == CW'(1));
      end
   end
endmodule // rss_gap_timer
`default_nettype wire

/* rss_sequencer.sv */
// Rail strobe sequencer: sequencing registers, strobe stepping and buck rail enables.
`include "rss_regs.svh"
`default_nettype none
module rss_sequencer
   import rss_pkg::*;
#(
   parameter int CW        = 20,
   parameter int SHORT_CYC = `RSS_GAP_SHORT_CYC,
   parameter int LONG_CYC  = `RSS_GAP_LONG_CYC,
   parameter int PD_FACTOR = `RSS_PD_FACTOR
) (
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst_b,
   input  wire rss_reg_req_t i_reg,
   input  wire logic         i_unlocked,
   input  wire logic         i_power_up_req,
   input  wire logic         i_power_down_req,
   output logic [7:0]        o_reg_rdata,
   output logic [3:0]        o_strobe,
   output logic              o_strobe_pulse,
   output logic              o_busy,
   output logic              o_first_buck_rail_en,
   output logic              o_second_buck_rail_en
);
   logic [7:0]    delay_low_q;
   logic [7:0]    delay_high_q;
   logic [7:0]    buck_assign_q;
   rss_state_t    state_q;
   logic [3:0]    strobe_q;
   logic          fire_q;
   logic          timer_done;
   logic          timer_start;
   logic [CW-1:0] gap_load;
   logic [8:0]    gap_sel;
   logic [3:0]    gap_idx;
   logic          wr_ok;

   // True when a slot field names this strobe; values outside 3h..Ah never match.
   function automatic logic slot_hit(input logic [3:0] slot, input logic [3:0] strobe);
      slot_hit = (slot >= `RSS_SLOT_FIRST) && (slot <= `RSS_SLOT_LAST)
                 && (slot == strobe);
   endfunction

   assign wr_ok = i_reg.wr && i_unlocked;

   // Register writes; a locked write is dropped silently.
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         delay_low_q   <= `RSS_RST_DELAY_LOW;
         delay_high_q  <= `RSS_RST_DELAY_HIGH;
         buck_assign_q <= `RSS_RST_BUCK_ASSIGN;
      end else if (wr_ok) begin
         if (i_reg.addr == `RSS_ADDR_DELAY_LOW) begin
            delay_low_q <= i_reg.wdata;
         end else if (i_reg.addr == `RSS_ADDR_DELAY_HIGH) begin
            delay_high_q <= i_reg.wdata & `RSS_HIGH_RW_MASK;
         end else if (i_reg.addr == `RSS_ADDR_BUCK_ASSIGN) begin
            buck_assign_q <= i_reg.wdata;
         end
      end
   end

   // Read data is registered; unmapped offsets read zero.
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg.addr == `RSS_ADDR_DELAY_LOW) begin
         o_reg_rdata <= delay_low_q;
      end else if (i_reg.addr == `RSS_ADDR_DELAY_HIGH) begin
         o_reg_rdata <= delay_high_q;
      end else if (i_reg.addr == `RSS_ADDR_BUCK_ASSIGN) begin
         o_reg_rdata <= buck_assign_q;
      end else begin
         o_reg_rdata <= 8'h00;
      end
   end

   // Gap n follows strobe n on the way up and precedes it on the way down.
   assign gap_sel = {delay_high_q[`RSS_BIT_GAP_NINE], delay_low_q};
   assign gap_idx = (state_q == RSS_DOWN) ? strobe_q - 4'h2 : strobe_q - 4'h1;

   // Gap length; the multiplier only applies on the way down.
   always_comb begin
      gap_load = gap_sel[gap_idx] ? CW'(LONG_CYC) : CW'(SHORT_CYC);
      if (state_q == RSS_DOWN && delay_high_q[`RSS_BIT_PD_MULT]) begin
         gap_load = gap_sel[gap_idx] ? CW'(LONG_CYC * PD_FACTOR)
                                     : CW'(SHORT_CYC * PD_FACTOR);
      end
   end

   // A gap starts at every strobe except the last of the direction.
   assign timer_start = fire_q
                        && !(state_q == RSS_UP && strobe_q == `RSS_STROBE_LAST)
                        && !(state_q == RSS_DOWN && strobe_q == `RSS_STROBE_FIRST);

   rss_gap_timer #(.CW(CW)) u_gap_timer (
      .i_sys_clk (i_sys_clk),
      .i_rst_b   (i_rst_b),
      .i_start   (timer_start),
      .i_load    (gap_load),
      .o_done    (timer_done)
   );

   // Strobe stepping; requests are ignored while a sequence runs.
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         state_q  <= RSS_IDLE;
         strobe_q <= 4'h0;
         fire_q   <= 1'b0;
      end else begin
         fire_q <= 1'b0;
         case (state_q)
            RSS_IDLE: begin
               if (i_power_up_req) begin
                  state_q  <= RSS_UP;
                  strobe_q <= `RSS_STROBE_FIRST;
                  fire_q   <= 1'b1;
               end else if (i_power_down_req) begin
                  state_q  <= RSS_DOWN;
                  strobe_q <= `RSS_STROBE_LAST;
                  fire_q   <= 1'b1;
               end
            end
            RSS_UP: begin
               if (timer_done) begin
                  strobe_q <= strobe_q + 4'h1;
                  fire_q   <= 1'b1;
               end else if (fire_q && strobe_q == `RSS_STROBE_LAST) begin
                  state_q <= RSS_IDLE;
               end
            end
            RSS_DOWN: begin
               if (timer_done) begin
                  strobe_q <= strobe_q - 4'h1;
                  fire_q   <= 1'b1;
               end else if (fire_q && strobe_q == `RSS_STROBE_FIRST) begin
                  state_q <= RSS_IDLE;
               end
            end
            default: begin
               state_q <= RSS_IDLE;
            end
         endcase
      end
   end

   // Rails switch only at their own strobe; unsequenced rails hold their level.
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         o_first_buck_rail_en  <= 1'b0;
         o_second_buck_rail_en <= 1'b0;
      end else if (fire_q) begin
         if (slot_hit(buck_assign_q[`RSS_BUCK_ONE_MSB:`RSS_BUCK_ONE_LSB], strobe_q)) begin
            o_first_buck_rail_en <= (state_q == RSS_UP);
         end
         if (slot_hit(buck_assign_q[`RSS_BUCK_TWO_MSB:`RSS_BUCK_TWO_LSB], strobe_q)) begin
            o_second_buck_rail_en <= (state_q == RSS_UP);
         end
      end
   end

   // Strobe status mirrors, one cycle behind the internal strobe.
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         o_strobe       <= 4'h0;
         o_strobe_pulse <= 1'b0;
         o_busy         <= 1'b0;
      end else begin
         o_strobe       <= strobe_q;
         o_strobe_pulse <= fire_q;
         o_busy         <= (state_q != RSS_IDLE);
      end
   end

   // Helper logic measuring the spacing between strobes for the checks below.
   logic [CW:0]   gap_cnt_q;
   logic [CW-1:0] exp_q;
   logic          armed_q;
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         gap_cnt_q <= '0;
         exp_q     <= '0;
         armed_q   <= 1'b0;
      end else if (fire_q) begin
         gap_cnt_q <= (CW+1)'(1);
         exp_q     <= gap_load;
         armed_q   <= timer_start;
      end else begin
         gap_cnt_q <= gap_cnt_q + (CW+1)'(1);
      end
   end

   a_gap_up_len: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      fire_q && armed_q && state_q == RSS_UP |-> gap_cnt_q == (CW+1)'(exp_q) + (CW+1)'(2))
      else $error("power-up gap length wrong");
   a_gap_nine_sel: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      fire_q && state_q == RSS_UP && strobe_q == 4'h9 |->
      gap_load == (delay_high_q[0] ? CW'(LONG_CYC) : CW'(SHORT_CYC)))
      else $error("gap nine select wrong");
   a_gap_down_len: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      fire_q && armed_q && state_q == RSS_DOWN |-> gap_cnt_q == (CW+1)'(exp_q) + (CW+1)'(2))
      else $error("power-down gap length wrong");
   a_up_unscaled: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      timer_start && state_q == RSS_UP |->
      (gap_load == CW'(SHORT_CYC) || gap_load == CW'(LONG_CYC)))
      else $error("power-up gap was scaled");
   a_rail_on_slot: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      $rose(o_first_buck_rail_en) |-> $past(slot_hit(buck_assign_q[3:0], strobe_q))
      && $past(fire_q))
      else $error("first rail enabled off its strobe");
   a_reserved_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      i_reg.addr == `RSS_ADDR_DELAY_HIGH |=> o_reg_rdata[6:1] == 6'h00)
      else $error("reserved bits not zero");
   a_reset_values: assert property (@(posedge i_sys_clk)
      !i_rst_b |=> delay_low_q == 8'h00 && buck_assign_q == 8'h98 && delay_high_q == 8'h00)
      else $error("reset value wrong");
   a_locked_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      i_reg.wr && !i_unlocked |=> $stable(delay_low_q) && $stable(delay_high_q)
      && $stable(buck_assign_q))
      else $error("locked write took effect");
endmodule // rss_sequencer
`default_nettype wire

/* rss_host_model.sv */
// Host model that drives register requests and the unlock level of the strobe sequencer.
`default_nettype none
module rss_host_model
   import rss_pkg::*;
(
   input  wire logic       i_sys_clk,
   input  wire logic [7:0] i_rdata,
   output rss_reg_req_t    o_reg,
   output logic            o_unlocked
);
   timeunit 1ns;
   timeprecision 1ns;

   // The bus starts idle and the registers start locked.
   initial begin
      o_reg      = '0;
      o_unlocked = 1'b0;
   end

   // The unlock is a level that the host keeps until it changes it.
   task automatic unlock(input logic v);
      @(posedge i_sys_clk);
      o_unlocked <= v;
   endtask

   // One write strobe per call; the data is inverted on release so stale data cannot pass.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      o_reg <= '{wr: 1'b1, addr: a, wdata: d};
      @(posedge i_sys_clk);
      o_reg <= '{wr: 1'b0, addr: a, wdata: ~d};
   endtask

   // The address is held two edges, since read data lags the address by one cycle.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_sys_clk);
      o_reg <= '{wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge i_sys_clk);
      @(posedge i_sys_clk);
      d = i_rdata;
   endtask
endmodule // rss_host_model
`default_nettype wire

/* rail_strobe_sequencer_tb.sv */
// Self-checking bench for the rail strobe sequencer.
`default_nettype none
module rail_strobe_sequencer_tb import rss_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   // Short gap counts keep the run brief; every gap expectation derives from them.
   localparam int SC = 20;
   localparam int LC = 50;
   logic         i_sys_clk = 1'b0;
   logic         i_rst_b   = 1'b0;
   logic         up_req    = 1'b0;
   logic         dn_req    = 1'b0;
   rss_reg_req_t reg_req;
   logic         unlocked;
   logic [7:0]   rdata;
   logic [7:0]   rd_v;
   logic [3:0]   strobe;
   logic         pulse;
   logic         busy;
   logic         rail1;
   logic         rail2;
   logic         e1 = 1'b0;
   logic         e2 = 1'b0;
   int           fail_count = 0;
   int           checked = 0;
   int           cycles = 0;

   // A 100 ns clock period.
   always #50 i_sys_clk = ~i_sys_clk;

   rss_sequencer #(.CW(20), .SHORT_CYC(SC), .LONG_CYC(LC), .PD_FACTOR(10)) dut_u (
      .i_sys_clk            (i_sys_clk),
      .i_rst_b              (i_rst_b),
      .i_reg                (reg_req),
      .i_unlocked           (unlocked),
      .i_power_up_req       (up_req),
      .i_power_down_req     (dn_req),
      .o_reg_rdata          (rdata),
      .o_strobe             (strobe),
      .o_strobe_pulse       (pulse),
      .o_busy               (busy),
      .o_first_buck_rail_en (rail1),
      .o_second_buck_rail_en(rail2)
   );

   rss_host_model host_u (
      .i_sys_clk (i_sys_clk),
      .i_rdata   (rdata),
      .o_reg     (reg_req),
      .o_unlocked(unlocked)
   );

   // Counts a comparison and reports it at once if it differs.
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Prints the verdict and ends the run.
   task automatic test_done;
      if (fail_count == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // A hang is cut short well above the longest expected run.
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         test_done();
      end
   end

   // Reads one register and compares it with the expected value.
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      host_u.rd(a, rd_v);
      chk("register", {8'h00, rd_v}, {8'h00, e});
   endtask

   // Runs one sequence; each strobe's number, spacing and rail levels are checked at its pulse.
   task automatic run(input logic down, input logic [8:0] g, input int m,
                      input logic [3:0] s1, input logic [3:0] s2);
      int n;
      int cnt;
      // Both requests together on the way up, since the up request must win.
      @(posedge i_sys_clk);
      up_req <= !down;
      dn_req <= 1'b1;
      @(posedge i_sys_clk);
      dn_req <= 1'b0;
      up_req <= 1'b0;
      for (int k = 0; k < 10; k++) begin
         cnt = 0;
         do begin
            @(posedge i_sys_clk);
            // A request in mid-sequence must be ignored while busy.
            up_req <= (k == 4 && cnt == 2);
            dn_req <= (k == 4 && cnt == 2);
            #1;
            cnt++;
         end while (pulse !== 1'b1 && cnt < 6000);
         n = down ? 10 - k : k + 1;
         if (s1 == n[3:0] && s1 >= 4'h3 && s1 <= 4'ha) e1 = !down;
         if (s2 == n[3:0] && s2 >= 4'h3 && s2 <= 4'ha) e2 = !down;
         chk("strobe", {12'h000, strobe}, n[15:0]);
         chk("busy", {15'h0000, busy}, 16'h0001);
         chk("rail one", {15'h0000, rail1}, {15'h0000, e1});
         chk("rail two", {15'h0000, rail2}, {15'h0000, e2});
         if (k > 0) chk("gap", cnt[15:0], 16'((g[down ? 9 - k : k - 1] ? LC : SC) * m + 2));
      end
      repeat (3) @(posedge i_sys_clk);
      #1;
      chk("idle", {15'h0000, busy}, 16'h0000);
   endtask

   // Reset, register map, locked writes, then four sequences.
   initial begin
      repeat (12) @(posedge i_sys_clk);
      i_rst_b <= 1'b1;
      rchk(8'h20, 8'h00);
      rchk(8'h21, 8'h00);
      rchk(8'h22, 8'h98);
      rchk(8'h23, 8'h00);
      host_u.wr(8'h20, 8'hff);
      rchk(8'h20, 8'h00);
      host_u.unlock(1'b1);
      host_u.wr(8'h21, 8'hff);
      rchk(8'h21, 8'h81);
      host_u.wr(8'h20, 8'h55);
      rchk(8'h20, 8'h55);
      host_u.wr(8'h22, 8'h3a);
      rchk(8'h22, 8'h3a);
      // Factor bit set: power-up stays unscaled, power-down stretches tenfold.
      run(1'b0, 9'h155, 1, 4'ha, 4'h3);
      run(1'b1, 9'h155, 10, 4'ha, 4'h3);
      host_u.wr(8'h21, 8'h00);
      host_u.wr(8'h22, 8'hb2);
      rchk(8'h22, 8'hb2);
      // Slots outside 3h..Ah leave both rails untouched.
      run(1'b0, 9'h055, 1, 4'h2, 4'hb);
      run(1'b1, 9'h055, 1, 4'h2, 4'hb);
      test_done();
   end
endmodule // rail_strobe_sequencer_tb
`default_nettype wire
